// file: include/pse_pkg.sv
/*
  Constants, register map and field layout of the link summary status and
  event interrupt enable block. Assumes an APB master with 32-bit data.
*/
package pse_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned REG_W           = 16;
  // Printed offsets are word indices; byte address is four times each
  localparam logic [ADDR_W-1:0] IDX_SUMMARY = 12'h011;
  localparam logic [ADDR_W-1:0] IDX_ENABLE  = 12'h012;
  localparam logic [ADDR_W-1:0] IDX_PENDING = 12'h013;

  // ----------------------------------------------------------------
  // Summary field positions
  // ----------------------------------------------------------------
  localparam int unsigned SUM_RATE_LO  = 14;
  localparam int unsigned SUM_DUPLEX   = 13;
  localparam int unsigned SUM_PAGE     = 12;
  localparam int unsigned SUM_RESOLVED = 11;
  localparam int unsigned SUM_LINK     = 10;
  localparam int unsigned SUM_CD_X     = 9;
  localparam int unsigned SUM_AB_X     = 8;
  localparam int unsigned SUM_MASKING  = 7;
  localparam int unsigned SUM_SLEEP    = 6;
  localparam int unsigned SUM_POL_LO   = 2;
  localparam int unsigned SUM_TEN_POL  = 1;
  localparam int unsigned SUM_JABBER   = 0;

  localparam logic [1:0] RATE_10M   = 2'h0;
  localparam logic [1:0] RATE_100M  = 2'h1;
  localparam logic [1:0] RATE_1000M = 2'h2;

  // ----------------------------------------------------------------
  // Event bit positions (enable and pending share the layout)
  // ----------------------------------------------------------------
  localparam int unsigned EV_NEG_FAULT = 15;
  localparam int unsigned EV_RATE      = 14;
  localparam int unsigned EV_DUPLEX    = 13;
  localparam int unsigned EV_PAGE      = 12;
  localparam int unsigned EV_NEG_DONE  = 11;
  localparam int unsigned EV_LINK      = 10;
  localparam int unsigned EV_FALSE_CAR = 8;
  localparam int unsigned EV_CROSSOVER = 6;
  localparam int unsigned EV_DOWNSHIFT = 5;
  localparam int unsigned EV_DORMANT   = 4;
  localparam int unsigned EV_WAKE      = 3;
  localparam logic [REG_W-1:0] EV_MASK = 16'hfd78;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] SUMMARY_RST = 16'h0002;
  localparam logic [REG_W-1:0] ENABLE_RST  = 16'h0000;
  localparam logic [REG_W-1:0] PENDING_RST = 16'h0000;

  typedef enum logic [1:0] {
    PSE_IDLE = 2'b01,
    PSE_RESP = 2'b10
  } pse_apb_state_t;

endpackage : pse_pkg

// file: logic/pse_sticky.sv
/*
  Bank of sticky flags. Each flag sets on its event pulse and clears on a
  clear-on-read strobe or a write of one. Assumes one clock domain.
*/
`timescale 1ns/100ps
module pse_sticky
  import pse_pkg::*;
#(
  parameter logic [pse_pkg::REG_W-1:0] RST_VAL = pse_pkg::PENDING_RST
) (
  input  wire logic                    pclk,      // Core clock
  input  wire logic                    presetn,   // Async reset, active low
  input  wire logic [pse_pkg::REG_W-1:0] set_vec, // Event pulses
  input  wire logic [pse_pkg::REG_W-1:0] clr_vec, // Bits to clear
  output logic      [pse_pkg::REG_W-1:0] flag_q   // Held flags
);

  logic [REG_W-1:0] flag_ff;
  logic [REG_W-1:0] nxt_flag;

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  // A set in the clearing cycle wins so no event is lost
  always_comb begin
    nxt_flag = (flag_ff & ~clr_vec) | set_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= RST_VAL;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_q = flag_ff;

endmodule : pse_sticky

// file: logic/pse_status_irq.sv
/*
  Link summary status and event interrupt enable registers with an APB
  slave, event pending flags and a level interrupt. Assumes the status
  inputs are synchronous to pclk and event inputs are one-cycle pulses.
*/
`timescale 1ns/100ps
module pse_status_irq
  import pse_pkg::*;
(
  input  wire logic                      pclk,          // Core clock
  input  wire logic                      presetn,       // Async reset, low
  input  wire logic                      psel,          // APB select
  input  wire logic                      penable,       // APB access phase
  input  wire logic                      pwrite,        // APB direction
  input  wire logic [pse_pkg::ADDR_W-1:0] paddr,        // APB byte address
  input  wire logic [pse_pkg::DATA_W-1:0] pwdata,       // APB write data
  input  wire logic [3:0]                pstrb,         // APB byte strobes
  output logic      [pse_pkg::DATA_W-1:0] prdata,       // APB read data
  output logic                           pready,        // APB ready
  output logic                           pslverr,       // APB error
  input  wire logic [1:0]                resolved_rate, // Rate code
  input  wire logic                      full_duplex,   // 1 full duplex
  input  wire logic                      neg_resolved,  // Negotiation done
  input  wire logic                      link_up,       // Link up
  input  wire logic                      pair_cd_crossed,        // C/D MDIX
  input  wire logic                      pair_ab_crossed,        // A/B MDIX
  input  wire logic                      gigabit_masking_active, // Masked
  input  wire logic                      dormant,       // In sleep mode
  input  wire logic [3:0]                channel_polarity_reversed, // D..A
  input  wire logic                      ten_polarity_ok, // 10M polarity
  input  wire logic                      basic_status_jabber, // Jabber lvl
  input  wire logic                      page_rx_pulse,   // Page received
  input  wire logic                      neg_fault_pulse, // Negotiation err
  input  wire logic                      false_carrier_pulse, // False CRS
  input  wire logic                      downshift_pulse, // Speed opt event
  input  wire logic                      wake_packet_pulse, // Wake packet
  output logic                           irq            // Interrupt, high
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pse_apb_state_t     state_ff;
  pse_apb_state_t     nxt_state;
  logic [DATA_W-1:0]  prdata_ff;
  logic [DATA_W-1:0]  nxt_prdata;
  logic               pslverr_ff;
  logic               nxt_pslverr;
  logic [REG_W-1:0]   enable_ff;
  logic [1:0]         rate_ff;
  logic               duplex_ff;
  logic               resolved_ff;
  logic               link_ff;
  logic               cd_x_ff;
  logic               ab_x_ff;
  logic               masking_ff;
  logic               sleep_ff;
  logic [3:0]         pol_ff;
  logic               ten_pol_ff;
  logic               jabber_ff;
  logic               page_ff;
  logic [REG_W-1:0]   summary;
  logic [REG_W-1:0]   pending;
  logic [REG_W-1:0]   ev_set;
  logic [REG_W-1:0]   pend_clr;
  logic               setup;
  logic               done;
  logic               rd_summary;
  logic               rd_pending;
  logic               wr_enable;
  logic               wr_pending;
  logic               gig_linked;

  // Word index of a byte address, or all ones when not word aligned
  function automatic logic [ADDR_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = (a[1:0] == 2'h0) ? {2'h0, a[ADDR_W-1:2]} : {ADDR_W{1'b1}};
  endfunction : word_idx

  // Merge a byte-strobed write into the low 16 bits of a register
  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                                input logic [DATA_W-1:0] wd,
                                                input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle, so the access phase
  // completes at once: zero wait states, data still from a flop.
  assign setup = psel && !penable;
  assign done  = psel && penable && pready;

  always_comb begin
    case (state_ff)
      PSE_IDLE: nxt_state = setup ? PSE_RESP : PSE_IDLE;
      PSE_RESP: nxt_state = done ? (setup ? PSE_RESP : PSE_IDLE) : PSE_RESP;
      default:  nxt_state = PSE_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PSE_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pready  = (state_ff == PSE_RESP);
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff && pready;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign rd_summary = done && !pwrite && (word_idx(paddr) == IDX_SUMMARY);
  assign rd_pending = done && !pwrite && (word_idx(paddr) == IDX_PENDING);
  assign wr_enable  = done && pwrite && (word_idx(paddr) == IDX_ENABLE);
  assign wr_pending = done && pwrite && (word_idx(paddr) == IDX_PENDING);

  always_comb begin
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (setup) begin
      nxt_prdata  = '0;
      nxt_pslverr = 1'b0;
      case (word_idx(paddr))
        IDX_SUMMARY: nxt_prdata[REG_W-1:0] = summary;
        IDX_ENABLE:  nxt_prdata[REG_W-1:0] = enable_ff;
        IDX_PENDING: nxt_prdata[REG_W-1:0] = pending;
        default:     nxt_pslverr = 1'b1;
      endcase
      if (pwrite) begin
        nxt_prdata = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Event interrupt enable register
  // ----------------------------------------------------------------
  // Reserved bits never store, so they read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= ENABLE_RST;
    end else if (wr_enable) begin
      enable_ff <= merge16(enable_ff, pwdata, pstrb) & EV_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Status sampling
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_ff     <= RATE_10M;
      duplex_ff   <= 1'b0;
      resolved_ff <= 1'b0;
      link_ff     <= 1'b0;
      cd_x_ff     <= 1'b0;
      ab_x_ff     <= 1'b0;
      masking_ff  <= 1'b0;
      sleep_ff    <= 1'b0;
      ten_pol_ff  <= SUMMARY_RST[SUM_TEN_POL];
      jabber_ff   <= 1'b0;
    end else begin
      rate_ff     <= resolved_rate;
      duplex_ff   <= full_duplex;
      resolved_ff <= neg_resolved;
      link_ff     <= link_up;
      cd_x_ff     <= pair_cd_crossed;
      ab_x_ff     <= pair_ab_crossed;
      masking_ff  <= gigabit_masking_active && !neg_resolved;
      sleep_ff    <= dormant;
      ten_pol_ff  <= ten_polarity_ok;
      jabber_ff   <= basic_status_jabber;
    end
  end

  // Polarity per channel only has meaning once a gigabit link is up
  assign gig_linked = link_up && (resolved_rate == RATE_1000M);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_ff <= 4'h0;
    end else begin
      pol_ff <= gig_linked ? channel_polarity_reversed : 4'h0;
    end
  end

  // Only the value that was returned is cleared, so a page arriving
  // between setup and access is kept for the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_ff <= 1'b0;
    end else if (page_rx_pulse) begin
      page_ff <= 1'b1;
    end else if (rd_summary && prdata_ff[SUM_PAGE]) begin
      page_ff <= 1'b0;
    end
  end

  always_comb begin
    summary                           = '0;
    summary[SUM_RATE_LO+1:SUM_RATE_LO] = rate_ff;
    summary[SUM_DUPLEX]               = duplex_ff;
    summary[SUM_PAGE]                 = page_ff;
    summary[SUM_RESOLVED]             = resolved_ff;
    summary[SUM_LINK]                 = link_ff;
    summary[SUM_CD_X]                 = cd_x_ff;
    summary[SUM_AB_X]                 = ab_x_ff;
    summary[SUM_MASKING]              = masking_ff;
    summary[SUM_SLEEP]                = sleep_ff;
    summary[SUM_POL_LO+3:SUM_POL_LO]  = pol_ff;
    summary[SUM_TEN_POL]              = ten_pol_ff;
    summary[SUM_JABBER]               = jabber_ff;
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Change events compare live inputs against the sampled copy; a
  // status that differs from its reset value fires once after reset.
  always_comb begin
    ev_set               = '0;
    ev_set[EV_NEG_FAULT] = neg_fault_pulse;
    ev_set[EV_RATE]      = (resolved_rate != rate_ff);
    ev_set[EV_DUPLEX]    = (full_duplex != duplex_ff);
    ev_set[EV_PAGE]      = page_rx_pulse;
    ev_set[EV_NEG_DONE]  = neg_resolved && !resolved_ff;
    ev_set[EV_LINK]      = (link_up != link_ff);
    ev_set[EV_FALSE_CAR] = false_carrier_pulse;
    ev_set[EV_CROSSOVER] = (pair_cd_crossed != cd_x_ff) || (pair_ab_crossed != ab_x_ff);
    ev_set[EV_DOWNSHIFT] = downshift_pulse;
    ev_set[EV_DORMANT]   = (dormant != sleep_ff);
    ev_set[EV_WAKE]      = wake_packet_pulse;
  end

  // Clear on read of what was returned, or by writing ones
  always_comb begin
    pend_clr = '0;
    if (rd_pending) begin
      pend_clr = prdata_ff[REG_W-1:0];
    end else if (wr_pending) begin
      pend_clr = merge16('0, pwdata, pstrb);
    end
  end

  // ----------------------------------------------------------------
  // Pending flags and interrupt
  // ----------------------------------------------------------------
  pse_sticky #(
    .RST_VAL (PENDING_RST)
  ) u_pending (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (ev_set & EV_MASK),
    .clr_vec (pend_clr),
    .flag_q  (pending)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(pending & enable_ff);
    end
  end

endmodule : pse_status_irq

// file: tb/pse_status_irq_chk.sv
/*
  Checker for pse_status_irq: summary fields, enable readback and interrupt.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module pse_chk
  import pse_pkg::*;
(
  input wire logic                       pclk,                      // Clock
  input wire logic                       presetn,                   // Reset, low
  input wire logic                       psel,                      // Select
  input wire logic                       penable,                   // Access
  input wire logic                       pwrite,                    // Direction
  input wire logic [pse_pkg::ADDR_W-1:0] paddr,                     // Address
  input wire logic [pse_pkg::DATA_W-1:0] pwdata,                    // Write data
  input wire logic [3:0]                 pstrb,                     // Strobes
  input wire logic [pse_pkg::DATA_W-1:0] prdata,                    // Read data
  input wire logic                       pready,                    // Ready
  input wire logic                       pslverr,                   // Error
  input wire logic [1:0]                 resolved_rate,             // Rate
  input wire logic                       neg_resolved,              // Resolved
  input wire logic                       link_up,                   // Link
  input wire logic                       gigabit_masking_active,    // Masking
  input wire logic [3:0]                 channel_polarity_reversed, // Polarity
  input wire logic                       ten_polarity_ok,           // 10M pol
  input wire logic                       basic_status_jabber,       // Jabber
  input wire logic                       wake_packet_pulse,         // Wake
  input wire logic                       irq                        // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Shadow of the enable register, rebuilt from completed writes
  // ----------------------------------------------------------------
  logic [REG_W-1:0] en_ff;
  logic             acc;
  logic             rd_sum;
  logic             rd_en;
  assign acc    = psel && penable && pready;
  assign rd_sum = acc && !pwrite && paddr == {IDX_SUMMARY[9:0], 2'b00};
  assign rd_en  = acc && !pwrite && paddr == {IDX_ENABLE[9:0], 2'b00};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= '0;
    end else if (acc && pwrite && !pslverr && paddr == {IDX_ENABLE[9:0], 2'b00}) begin
      en_ff <= {pstrb[1] ? pwdata[15:8] : en_ff[15:8],
                pstrb[0] ? pwdata[7:0] : en_ff[7:0]} & EV_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rate; rd_sum |-> prdata[15:14] == $past(resolved_rate, 2); endproperty
  a_rate: assert property (p_rate) else $error("rate field wrong");
  property p_done; rd_sum |-> prdata[11] == $past(neg_resolved, 2); endproperty
  a_done: assert property (p_done) else $error("resolved bit wrong");
  property p_mask;
    rd_sum |-> prdata[7] == ($past(gigabit_masking_active, 2) && !$past(neg_resolved, 2));
  endproperty
  a_mask: assert property (p_mask) else $error("masking bit wrong");
  property p_pol;
    rd_sum |-> prdata[5:2] == (($past(link_up, 2) && $past(resolved_rate, 2) == RATE_1000M)
                               ? $past(channel_polarity_reversed, 2) : 4'h0);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity bits wrong");
  property p_line;
    rd_sum |-> prdata[1:0] == {$past(ten_polarity_ok, 2), $past(basic_status_jabber, 2)};
  endproperty
  a_line: assert property (p_line) else $error("polarity or jabber wrong");
  property p_en_rd; rd_en |-> prdata == {16'h0, en_ff}; endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
  // Interrupt is registered, so it answers the enables of the cycle before
  property p_irq_src; irq |-> $past(en_ff) != '0; endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq with no enable");
  property p_irq_ev; wake_packet_pulse && en_ff[EV_WAKE] |-> ##[1:3] irq; endproperty
  a_irq_ev: assert property (p_irq_ev) else $error("enabled event gave no irq");
endmodule : pse_chk

bind pse_status_irq pse_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .resolved_rate, .neg_resolved, .link_up,
  .gigabit_masking_active, .channel_polarity_reversed, .ten_polarity_ok,
  .basic_status_jabber, .wake_packet_pulse, .irq);

// file: tb/tb.sv
/*
  Self-checking bench for pse_status_irq: reset values, summary fields,
  enable register, pending flags and interrupt. Assumes pse_pkg.
*/
`timescale 1ns/100ps
module tb;
  import pse_pkg::*;
  localparam logic [ADDR_W-1:0] A_SUM = IDX_SUMMARY << 2;
  localparam logic [ADDR_W-1:0] A_EN  = IDX_ENABLE << 2;
  localparam logic [ADDR_W-1:0] A_PND = IDX_PENDING << 2;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]        pstrb, pol;
  logic [1:0]        rate;
  logic              dup, nres, lnk, cd, ab, gm, dor, ten, jab, pg, nf, fc, ds, wk;
  int                n_mismatch = 0;
  int                total_checks = 0;

  pse_status_irq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resolved_rate(rate), .full_duplex(dup),
    .neg_resolved(nres), .link_up(lnk), .pair_cd_crossed(cd), .pair_ab_crossed(ab),
    .gigabit_masking_active(gm), .dormant(dor), .channel_polarity_reversed(pol),
    .ten_polarity_ok(ten), .basic_status_jabber(jab), .page_rx_pulse(pg),
    .neg_fault_pulse(nf), .false_carrier_pulse(fc), .downshift_pulse(ds),
    .wake_packet_pulse(wk), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One transfer; the access phase is held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    // Sampled at the rising edge that completes the access, never mid-cycle
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t pready timeout", $time);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_reset();
    apb(1'b0, A_SUM, 32'h0, 4'h3); chk(rd, 32'h2, "summary reset");
    apb(1'b0, A_EN, 32'h0, 4'h3);  chk(rd, 32'h0, "enable reset");
    apb(1'b0, A_PND, 32'h0, 4'h3); chk(rd, 32'h0, "pending reset");
  endtask : t_reset

  task automatic t_summary();
    logic [1:0]  r2;
    logic [3:0]  p;
    logic [31:0] exp;
    for (int r = 0; r < 4; r++) begin
      r2 = 2'(r);
      p = 4'h9 ^ {2'h0, r2};
      @(posedge pclk);
      rate <= r2; dup <= r2[0]; nres <= r2[1]; lnk <= 1'b1; cd <= r2[0]; ab <= r2[1];
      gm <= 1'b1; dor <= r2[1]; pol <= p; ten <= r2[0]; jab <= r2[1];
      exp = {16'h0, r2, r2[0], 1'b0, r2[1], 1'b1, r2[0], r2[1], ~r2[1], r2[1],
             (r2 == RATE_1000M) ? p : 4'h0, r2[0], r2[1]};
      repeat (3) @(posedge pclk);
      apb(1'b0, A_SUM, 32'h0, 4'h3); chk(rd, exp, "summary");
    end
  endtask : t_summary

  task automatic t_page_jabber();
    @(posedge pclk); pg <= 1'b1; jab <= 1'b1; rate <= RATE_10M;
    @(posedge pclk); pg <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, A_SUM, 32'h0, 4'h3);
    chk(32'(rd[12]), 32'h1, "page latched");
    chk(32'(rd[0]), 32'h1, "jabber shown");
    apb(1'b0, A_SUM, 32'h0, 4'h3);
    chk(32'(rd[12]), 32'h0, "page cleared by read");
    chk(32'(rd[0]), 32'h1, "jabber kept after read");
  endtask : t_page_jabber

  task automatic t_enable();
    apb(1'b1, A_EN, 32'hffff_ffff, 4'h3);
    apb(1'b0, A_EN, 32'h0, 4'h3); chk(rd, {16'h0, EV_MASK}, "enable bits");
    apb(1'b1, A_EN, 32'h0, 4'h1);
    apb(1'b0, A_EN, 32'h0, 4'h3); chk(rd, 32'hfd00, "low lane only");
    apb(1'b1, A_SUM, 32'hffff_ffff, 4'h3);
    apb(1'b0, A_SUM, 32'h0, 4'h3); chk(32'(rd[15:14]), 32'h0, "summary read only");
    apb(1'b0, 12'h050, 32'h0, 4'h3); chk(32'(err), 32'h1, "unmapped error");
  endtask : t_enable

  task automatic t_irq();
    logic [15:0] bitv [5] = '{16'h8000, 16'h1000, 16'h0100, 16'h0020, 16'h0008};
    apb(1'b1, A_EN, 32'h0, 4'h3);
    // Rate, duplex, link, crossover, dormant, done and page all moved earlier
    apb(1'b0, A_PND, 32'h0, 4'h3); chk(rd, 32'h7c50, "change events latched");
    @(posedge pclk); wk <= 1'b1;
    @(posedge pclk); wk <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk); chk(32'(irq), 32'h0, "masked event");
    apb(1'b0, A_PND, 32'h0, 4'h3); chk(rd, 32'h8, "latched while masked");
    apb(1'b0, A_PND, 32'h0, 4'h3); chk(rd, 32'h0, "cleared by read");
    @(posedge pclk); wk <= 1'b1;
    @(posedge pclk); wk <= 1'b0;
    apb(1'b1, A_PND, 32'h8, 4'h1);
    apb(1'b0, A_PND, 32'h0, 4'h3); chk(rd, 32'h0, "cleared by writing one");
    apb(1'b1, A_EN, 32'hffff, 4'h3);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk); {nf, pg, fc, ds, wk} <= 5'h10 >> i;
      @(posedge pclk); {nf, pg, fc, ds, wk} <= 5'h0;
      repeat (3) @(posedge pclk);
      @(negedge pclk); chk(32'(irq), 32'h1, "enabled event irq");
      apb(1'b0, A_PND, 32'h0, 4'h3); chk(rd, {16'h0, bitv[i]}, "pending bit");
      repeat (2) @(posedge pclk);
      @(negedge pclk); chk(32'(irq), 32'h0, "irq after clear");
    end
  endtask : t_irq

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'h0; rate = 2'h0; pol = 4'h0; ten = 1'b1;
    {dup, nres, lnk, cd, ab, gm, dor, jab, pg, nf, fc, ds, wk} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_summary();
    t_page_jabber();
    t_enable();
    t_irq();
    end_of_test();
  end
endmodule : tb
